// ### include/umsna_regs.vh
// register map, field positions, reset values and codes of the modem status / network block
`ifndef UMSNA_REGS_VH
`define UMSNA_REGS_VH

// byte addresses of the registers
`define UMSNA_ADDR_MODEM_STATUS 32'hffff0718
`define UMSNA_ADDR_SCRATCH 32'hffff071c
`define UMSNA_ADDR_NET_ENABLE 32'hffff0720
`define UMSNA_ADDR_NET_IID 32'hffff0724
`define UMSNA_ADDR_MATCH 32'hffff0728
`define UMSNA_ADDR_FRAC_DIV 32'hffff072c

// reset values
`define UMSNA_RST_MODEM_STATUS 8'h00
`define UMSNA_RST_SCRATCH 8'h00
`define UMSNA_RST_NET_ENABLE 8'h04
`define UMSNA_RST_NET_IID 8'h01
`define UMSNA_RST_MATCH 8'haa
`define UMSNA_RST_FRAC_DIV 16'h0000

// modem status fields
`define UMSNA_MS_DELTA_CLEAR_TO_SEND 0
`define UMSNA_MS_DELTA_SET_READY 1
`define UMSNA_MS_RING_TRAILING_EDGE 2
`define UMSNA_MS_DELTA_CARRIER_DETECT 3
`define UMSNA_MS_CTS 4
`define UMSNA_MS_DSR 5
`define UMSNA_MS_RI 6
`define UMSNA_MS_DCD 7

// modem input order inside the synchroniser vector
`define UMSNA_IN_CTS 0
`define UMSNA_IN_DSR 1
`define UMSNA_IN_RING_N 2
`define UMSNA_IN_DCD 3

// scratch field used as transmitted address marker
`define UMSNA_SCR_ADDR_MARK 0

// fractional divider fields
`define UMSNA_FD_ON 15
`define UMSNA_FD_M_HI 12
`define UMSNA_FD_M_LO 11
`define UMSNA_FD_N_HI 10
`define UMSNA_FD_N_LO 0
`define UMSNA_FD_WR_MASK 16'h9fff
`define UMSNA_FD_M_ZERO_AS 3'h4

// network enable fields
`define UMSNA_NE_MODE_ON 7
`define UMSNA_NE_TX9_ON 6
`define UMSNA_NE_RX9_ON 5
`define UMSNA_NE_IRQ_ON 4
`define UMSNA_NE_DATA9 3
`define UMSNA_NE_PIN_DRV 2
`define UMSNA_NE_ADDR_POL 1
`define UMSNA_NE_SEND_ADDR 0

// identification codes, bits 3:1
`define UMSNA_IID_NONE 3'h0
`define UMSNA_IID_LINE_STATUS 3'h3
`define UMSNA_IID_RX_FULL 3'h2
`define UMSNA_IID_ADDR_MATCH 3'h6
`define UMSNA_IID_TX_EMPTY 3'h1
`define UMSNA_IID_ADDR_SENT 3'h5
`define UMSNA_IID_MODEM 3'h0

// cycles the modem inputs settle after reset before deltas count
`define UMSNA_SETTLE_CYCLES 3'h5

`endif

// ### hdl/umsna_sync3.v
// three-stage synchroniser with agreement filter, one lane per modem input
`timescale 1ns/10ps
`default_nettype none

module umsna_sync3 #(
	parameter WIDTH = 4
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] level_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
			reg meta_r;
			reg mid_r;
			reg late_r;
			reg level_r;
			// first stage feeds only the second; level moves when stages two and three agree
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_r <= 1'b0;
					mid_r <= 1'b0;
					late_r <= 1'b0;
					level_r <= 1'b0;
				end else begin
					meta_r <= async_i[g];
					mid_r <= meta_r;
					late_r <= mid_r;
					if (mid_r == late_r) begin
						level_r <= late_r;
					end
				end
			end
			assign level_o[g] = level_r;
		end
	endgenerate

endmodule // umsna_sync3

`default_nettype wire

// ### hdl/umsna_top.v
// modem status, scratch, fractional divider and network addressable mode registers
//
// Behaviour
// - delta clear-to-send flag, bit 0, set on CTS change, cleared by status read.
// - delta set-ready flag, bit 1, set on DSR change, cleared by status read.
// - ring trailing-edge flag, bit 2, set on ring input 0 to 1, read clears.
// - delta carrier flag, bit 3, set on DCD change, cleared by status read.
// - status upper bits show DCD 7, RI 6, DSR 5, CTS 4; read-only.
// - eight-bit scratch register, read/write, untouched by hardware.
// - in network mode scratch bit 0 or enable bit 0 gives ninth transmitted bit: 1 address.
// - divider bit 15 picks fractional generator, else standard divisor generator.
// - divider holds M in 12:11, N in 10:0; M of zero means four.
// - network enable bit 7 turns network address mode on and off.
// - network mode disables parity check; parity slot carries address marker.
// - network enable bit 6 enables nine-bit transmit, only in network mode.
// - network enable bit 5 enables nine-bit receive, only in network mode.
// - network enable bit 3 selects nine-bit data words in network mode, else eight-bit.
// - network enable bit 2 drives serial output pin; clear leaves it floating in network mode only.
// - network enable bit 0 selects sending slave address or data.
// - network enable bit 4 enables network interrupt; bit 1 sets address polarity.
// - identify register: code in bits 3:1, active-low pending in bit 0.
// - line status code 011 first; address match 110 second; receive full code 010 third.
// - address sent 101 fourth, then tx empty 001; modem status 000 last.
// - each received network address is compared with the match register.
// - matching address raises interrupt and code 110; receive read clears it.
`timescale 1ns/10ps
`default_nettype none
`include "umsna_regs.vh"

module umsna_top (
	input wire MCLK_I,
	input wire RSTN_I,
	// register port
	input wire [31:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	// modem pins
	input wire CTS_I,
	input wire DSR_I,
	input wire RING_N_I,
	input wire DCD_I,
	// events and strobes from the rest of the uart
	input wire LINE_STATUS_EVT_I,
	input wire LINE_STATUS_READ_I,
	input wire RX_FULL_EVT_I,
	input wire RX_READ_I,
	input wire TX_EMPTY_EVT_I,
	input wire TX_WRITE_I,
	input wire PRIMARY_IID_READ_I,
	input wire RX_WORD_VALID_I,
	input wire [7:0] RX_WORD_I,
	input wire RX_MARK_BIT_I,
	input wire SERIAL_OUT_I,
	// configuration to the rest of the uart
	output reg FRAC_GEN_ON_O,
	output reg [2:0] FRAC_M_O,
	output reg [10:0] FRAC_N_O,
	output reg NET_MODE_O,
	output reg PARITY_CHECK_OFF_O,
	output reg TX_MARK_BIT_O,
	output reg TX_NINE_BIT_O,
	output reg RX_NINE_BIT_O,
	output reg NINE_BIT_DATA_O,
	output reg NET_IRQ_O,
	// serial output pin
	output reg SERIAL_OUT_PIN_O,
	output reg SERIAL_OUT_OE_O
);

	wire [3:0] modem_lvl;
	wire cts_lvl;
	wire dsr_lvl;
	wire ring_n_lvl;
	wire dcd_lvl;
	reg [3:0] modem_prev_r;
	reg [2:0] settle_r;
	wire settled;
	reg [3:0] delta_r;
	reg [3:0] delta_nxt;
	reg [7:0] scratch_r;
	reg [7:0] net_enable_r;
	reg [7:0] match_r;
	reg [15:0] frac_div_r;
	reg line_status_pend_r;
	reg rx_full_pend_r;
	reg addr_match_pend_r;
	reg tx_empty_pend_r;
	reg addr_sent_pend_r;
	reg [2:0] iid_code;
	reg iid_pend_n;
	reg [31:0] rdata_nxt;
	wire sel_status;
	wire sel_scratch;
	wire sel_enable;
	wire sel_iid;
	wire sel_match;
	wire sel_frac;
	wire status_read;
	wire mode_on;
	wire cts_evt;
	wire dsr_evt;
	wire ring_evt;
	wire dcd_evt;
	wire rx_is_addr;
	wire addr_hit;
	wire sent_addr;
	wire [1:0] m_field;

	// modem inputs pass the three-stage synchroniser
	umsna_sync3 #(
		.WIDTH(4)
	) u_sync (
		.clk_i(MCLK_I),
		.rst_n_i(RSTN_I),
		.async_i({DCD_I, RING_N_I, DSR_I, CTS_I}),
		.level_o(modem_lvl)
	);

	assign cts_lvl = modem_lvl[`UMSNA_IN_CTS];
	assign dsr_lvl = modem_lvl[`UMSNA_IN_DSR];
	assign ring_n_lvl = modem_lvl[`UMSNA_IN_RING_N];
	assign dcd_lvl = modem_lvl[`UMSNA_IN_DCD];

	// address decode of the register port
	assign sel_status = (ADDR_I == `UMSNA_ADDR_MODEM_STATUS);
	assign sel_scratch = (ADDR_I == `UMSNA_ADDR_SCRATCH);
	assign sel_enable = (ADDR_I == `UMSNA_ADDR_NET_ENABLE);
	assign sel_iid = (ADDR_I == `UMSNA_ADDR_NET_IID);
	assign sel_match = (ADDR_I == `UMSNA_ADDR_MATCH);
	assign sel_frac = (ADDR_I == `UMSNA_ADDR_FRAC_DIV);
	assign status_read = RD_I & sel_status;

	assign mode_on = net_enable_r[`UMSNA_NE_MODE_ON];

	// hold off delta detection until the synchroniser has filled and the previous level caught up
	assign settled = (settle_r == `UMSNA_SETTLE_CYCLES);

	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			settle_r <= 3'h0;
			modem_prev_r <= 4'h0;
		end else begin
			if (!settled) begin
				settle_r <= settle_r + 3'h1;
			end
			modem_prev_r <= modem_lvl;
		end
	end

	// change detection on the filtered modem levels
	assign cts_evt = settled & (cts_lvl != modem_prev_r[`UMSNA_IN_CTS]);
	assign dsr_evt = settled & (dsr_lvl != modem_prev_r[`UMSNA_IN_DSR]);
	assign ring_evt = settled & ring_n_lvl & ~modem_prev_r[`UMSNA_IN_RING_N];
	assign dcd_evt = settled & (dcd_lvl != modem_prev_r[`UMSNA_IN_DCD]);

	// delta flags: a read clears them, a coinciding change sets them again
	always @* begin
		delta_nxt = delta_r;
		if (status_read) begin
			delta_nxt = 4'h0;
		end
		if (cts_evt) begin
			delta_nxt[`UMSNA_MS_DELTA_CLEAR_TO_SEND] = 1'b1;
		end
		if (dsr_evt) begin
			delta_nxt[`UMSNA_MS_DELTA_SET_READY] = 1'b1;
		end
		if (ring_evt) begin
			delta_nxt[`UMSNA_MS_RING_TRAILING_EDGE] = 1'b1;
		end
		if (dcd_evt) begin
			delta_nxt[`UMSNA_MS_DELTA_CARRIER_DETECT] = 1'b1;
		end
	end

	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			delta_r <= 4'h0;
		end else begin
			delta_r <= delta_nxt;
		end
	end

	// software-written registers; status and identify ignore writes
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			scratch_r <= `UMSNA_RST_SCRATCH;
			net_enable_r <= `UMSNA_RST_NET_ENABLE;
			match_r <= `UMSNA_RST_MATCH;
			frac_div_r <= `UMSNA_RST_FRAC_DIV;
		end else if (WR_I) begin
			if (sel_scratch) begin
				scratch_r <= WDATA_I[7:0];
			end
			if (sel_enable) begin
				net_enable_r <= WDATA_I[7:0];
			end
			if (sel_match) begin
				match_r <= WDATA_I[7:0];
			end
			if (sel_frac) begin
				frac_div_r <= WDATA_I[15:0] & `UMSNA_FD_WR_MASK;
			end
		end
	end

	// received word is an address when its marker bit matches the chosen polarity
	assign rx_is_addr = mode_on & net_enable_r[`UMSNA_NE_RX9_ON]
		& (RX_MARK_BIT_I ^ net_enable_r[`UMSNA_NE_ADDR_POL]);
	assign addr_hit = RX_WORD_VALID_I & rx_is_addr & (RX_WORD_I == match_r);

	// the word just sent was an address
	assign sent_addr = mode_on & (scratch_r[`UMSNA_SCR_ADDR_MARK]
		| net_enable_r[`UMSNA_NE_SEND_ADDR]);

	// sticky interrupt sources; set beats clear in the same cycle
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			line_status_pend_r <= 1'b0;
			rx_full_pend_r <= 1'b0;
			addr_match_pend_r <= 1'b0;
			tx_empty_pend_r <= 1'b0;
			addr_sent_pend_r <= 1'b0;
		end else begin
			// line status, cleared by reading line status
			line_status_pend_r <= LINE_STATUS_EVT_I
				| (line_status_pend_r & ~LINE_STATUS_READ_I);
			// receive buffer full, cleared by reading receive data
			rx_full_pend_r <= RX_FULL_EVT_I | (rx_full_pend_r & ~RX_READ_I);
			// address match, cleared by reading receive data
			addr_match_pend_r <= addr_hit | (addr_match_pend_r & ~RX_READ_I);
			// transmit empty after data, cleared by a transmit write or primary identify read
			tx_empty_pend_r <= (TX_EMPTY_EVT_I & ~sent_addr)
				| (tx_empty_pend_r & ~TX_WRITE_I & ~PRIMARY_IID_READ_I);
			// transmit empty after an address, same clearing
			addr_sent_pend_r <= (TX_EMPTY_EVT_I & sent_addr)
				| (addr_sent_pend_r & ~TX_WRITE_I & ~PRIMARY_IID_READ_I);
		end
	end

	// priority encoder of the identify register
	always @* begin
		iid_code = `UMSNA_IID_NONE;
		iid_pend_n = 1'b1;
		if (line_status_pend_r) begin
			iid_code = `UMSNA_IID_LINE_STATUS;
			iid_pend_n = 1'b0;
		end else if (addr_match_pend_r) begin
			iid_code = `UMSNA_IID_ADDR_MATCH;
			iid_pend_n = 1'b0;
		end else if (rx_full_pend_r) begin
			iid_code = `UMSNA_IID_RX_FULL;
			iid_pend_n = 1'b0;
		end else if (addr_sent_pend_r) begin
			iid_code = `UMSNA_IID_ADDR_SENT;
			iid_pend_n = 1'b0;
		end else if (tx_empty_pend_r) begin
			iid_code = `UMSNA_IID_TX_EMPTY;
			iid_pend_n = 1'b0;
		end else if (delta_r != 4'h0) begin
			iid_code = `UMSNA_IID_MODEM;
			iid_pend_n = 1'b0;
		end
	end

	// read data multiplexer; unmapped addresses read zero
	always @* begin
		rdata_nxt = 32'h00000000;
		if (RD_I) begin
			if (sel_status) begin
				rdata_nxt[`UMSNA_MS_DCD] = dcd_lvl;
				rdata_nxt[`UMSNA_MS_RI] = ~ring_n_lvl;
				rdata_nxt[`UMSNA_MS_DSR] = dsr_lvl;
				rdata_nxt[`UMSNA_MS_CTS] = cts_lvl;
				rdata_nxt[3:0] = delta_r;
			end else if (sel_scratch) begin
				rdata_nxt[7:0] = scratch_r;
			end else if (sel_enable) begin
				rdata_nxt[7:0] = net_enable_r;
			end else if (sel_iid) begin
				rdata_nxt[3:0] = {iid_code, iid_pend_n};
			end else if (sel_match) begin
				rdata_nxt[7:0] = match_r;
			end else if (sel_frac) begin
				rdata_nxt[15:0] = frac_div_r;
			end
		end
	end

	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RDATA_O <= 32'h00000000;
		end else begin
			RDATA_O <= rdata_nxt;
		end
	end

	// effective M: a zero field stands for four
	assign m_field = frac_div_r[`UMSNA_FD_M_HI:`UMSNA_FD_M_LO];

	// configuration outputs, registered from the control registers
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FRAC_GEN_ON_O <= 1'b0;
			FRAC_M_O <= `UMSNA_FD_M_ZERO_AS;
			FRAC_N_O <= 11'h000;
			NET_MODE_O <= 1'b0;
			PARITY_CHECK_OFF_O <= 1'b0;
			TX_MARK_BIT_O <= 1'b0;
			TX_NINE_BIT_O <= 1'b0;
			RX_NINE_BIT_O <= 1'b0;
			NINE_BIT_DATA_O <= 1'b0;
			NET_IRQ_O <= 1'b0;
		end else begin
			FRAC_GEN_ON_O <= frac_div_r[`UMSNA_FD_ON];
			FRAC_M_O <= (m_field == 2'h0) ? `UMSNA_FD_M_ZERO_AS : {1'b0, m_field};
			FRAC_N_O <= frac_div_r[`UMSNA_FD_N_HI:`UMSNA_FD_N_LO];
			NET_MODE_O <= mode_on;
			PARITY_CHECK_OFF_O <= mode_on;
			TX_MARK_BIT_O <= sent_addr;
			TX_NINE_BIT_O <= mode_on & net_enable_r[`UMSNA_NE_TX9_ON];
			RX_NINE_BIT_O <= mode_on & net_enable_r[`UMSNA_NE_RX9_ON];
			NINE_BIT_DATA_O <= mode_on & net_enable_r[`UMSNA_NE_DATA9];
			NET_IRQ_O <= mode_on & net_enable_r[`UMSNA_NE_IRQ_ON] & ~iid_pend_n;
		end
	end

	// serial output pin driver; released in reset, then always driven outside network mode
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			SERIAL_OUT_PIN_O <= 1'b1;
			SERIAL_OUT_OE_O <= 1'b0;
		end else begin
			SERIAL_OUT_PIN_O <= SERIAL_OUT_I;
			SERIAL_OUT_OE_O <= ~mode_on | net_enable_r[`UMSNA_NE_PIN_DRV];
		end
	end

endmodule // umsna_top

`default_nettype wire

// ### testbench/umsna_checker.sv
// port checker of the modem status and network block
`timescale 1ns/10ps
`default_nettype none
`include "umsna_regs.vh"

module umsna_checker (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic [31:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic SERIAL_OUT_I,
	input wire logic [2:0] FRAC_M_O,
	input wire logic NET_MODE_O,
	input wire logic PARITY_CHECK_OFF_O,
	input wire logic TX_MARK_BIT_O,
	input wire logic TX_NINE_BIT_O,
	input wire logic RX_NINE_BIT_O,
	input wire logic NINE_BIT_DATA_O,
	input wire logic SERIAL_OUT_PIN_O,
	input wire logic SERIAL_OUT_OE_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	// read data only in the cycle after a read
	a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data outside read cycle");
	// derived outputs land two edges after a write
	a_frac_m_map: assert property (WR_I && ADDR_I == `UMSNA_ADDR_FRAC_DIV |-> ##2
		FRAC_M_O == (($past(WDATA_I[12:11], 2) == 2'h0) ? 3'h4
		: {1'b0, $past(WDATA_I[12:11], 2)}))
		else $error("m factor wrong");
	a_mode_follow: assert property (WR_I && ADDR_I == `UMSNA_ADDR_NET_ENABLE |-> ##2
		NET_MODE_O == $past(WDATA_I[7], 2)
		&& RX_NINE_BIT_O == ($past(WDATA_I[7], 2) && $past(WDATA_I[5], 2)))
		else $error("mode outputs wrong");
	a_oe_follow: assert property (WR_I && ADDR_I == `UMSNA_ADDR_NET_ENABLE |-> ##2
		SERIAL_OUT_OE_O == (!$past(WDATA_I[7], 2) || $past(WDATA_I[2], 2)))
		else $error("pin enable wrong");
	a_parity_mode: assert property (PARITY_CHECK_OFF_O == NET_MODE_O)
		else $error("parity check state wrong");
	a_nine_gated: assert property (
		(TX_NINE_BIT_O || NINE_BIT_DATA_O || TX_MARK_BIT_O) |-> NET_MODE_O)
		else $error("network feature outside network mode");
	a_pin_follow: assert property ($past(RSTN_I) |-> SERIAL_OUT_PIN_O == $past(SERIAL_OUT_I))
		else $error("serial pin not following");
	a_iid_form: assert property (RD_I && ADDR_I == `UMSNA_ADDR_NET_IID |=>
		RDATA_O[7:4] == 4'h0 && (!RDATA_O[0] || RDATA_O[3:1] == 3'h0))
		else $error("identify format wrong");
endmodule // umsna_checker

bind umsna_top umsna_checker u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SERIAL_OUT_I(SERIAL_OUT_I),
	.FRAC_M_O(FRAC_M_O), .NET_MODE_O(NET_MODE_O), .PARITY_CHECK_OFF_O(PARITY_CHECK_OFF_O),
	.TX_MARK_BIT_O(TX_MARK_BIT_O), .TX_NINE_BIT_O(TX_NINE_BIT_O), .RX_NINE_BIT_O(RX_NINE_BIT_O),
	.NINE_BIT_DATA_O(NINE_BIT_DATA_O), .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
	.SERIAL_OUT_OE_O(SERIAL_OUT_OE_O));
`default_nettype wire

// ### testbench/umsna_modem_model.sv
// modem partner: asynchronous modem pins and serial traffic
`timescale 1ns/10ps
`default_nettype none
`include "umsna_regs.vh"

module umsna_modem_model (
	input wire logic clk_i,
	output logic cts_o,
	output logic dsr_o,
	output logic ring_n_o,
	output logic dcd_o,
	output logic ser_o
);
	logic [3:0] pins_r = 4'h4; // ring pin idles high
	logic [7:0] pat_r = 8'hb4;
	// pin levels
	assign cts_o = pins_r[`UMSNA_IN_CTS];
	assign dsr_o = pins_r[`UMSNA_IN_DSR];
	assign ring_n_o = pins_r[`UMSNA_IN_RING_N];
	assign dcd_o = pins_r[`UMSNA_IN_DCD];
	assign ser_o = pat_r[7];
	// changes land mid-cycle, unrelated to the sampling edge
	task automatic set_pin(input int idx, input logic v);
		#7;
		pins_r[idx] = v;
	endtask
	// line traffic rotates one pattern bit every cycle
	always @(posedge clk_i) begin
		pat_r <= {pat_r[6:0], pat_r[7]};
	end
endmodule // umsna_modem_model
`default_nettype wire

// ### testbench/test_umsna_top.sv
// self-checking testbench of the modem status and network block
`timescale 1ns/10ps
`default_nettype none
`include "umsna_regs.vh"

module test_umsna_top;
	localparam logic [31:0] ast = `UMSNA_ADDR_MODEM_STATUS;
	localparam logic [31:0] asc = `UMSNA_ADDR_SCRATCH;
	localparam logic [31:0] aen = `UMSNA_ADDR_NET_ENABLE;
	localparam logic [31:0] aid = `UMSNA_ADDR_NET_IID;
	localparam logic [31:0] amt = `UMSNA_ADDR_MATCH;
	localparam logic [31:0] afd = `UMSNA_ADDR_FRAC_DIV;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] evt = 7'h0; // iid0 read, tx write, tx empty, rx read, rx full, ls read, ls event
	logic vld = 1'b0;
	logic mark = 1'b0;
	logic [7:0] word = 8'h0;
	logic [31:0] rdata;
	logic cts, dsr, ring_n, dcd, ser, gen_on, mode, par_off, tx_mark, tx9, rx9, d9, irq, pin, oe;
	logic [2:0] fm;
	logic [10:0] fn;
	int failures = 0;
	int total_checks = 0;

	// core clock
	initial begin
		forever #20 mclk = ~mclk;
	end

	umsna_modem_model u_mdm (.clk_i(mclk), .cts_o(cts), .dsr_o(dsr), .ring_n_o(ring_n),
		.dcd_o(dcd), .ser_o(ser));

	umsna_top u_dut (.MCLK_I(mclk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .CTS_I(cts), .DSR_I(dsr), .RING_N_I(ring_n), .DCD_I(dcd),
		.LINE_STATUS_EVT_I(evt[0]), .LINE_STATUS_READ_I(evt[1]), .RX_FULL_EVT_I(evt[2]),
		.RX_READ_I(evt[3]), .TX_EMPTY_EVT_I(evt[4]), .TX_WRITE_I(evt[5]),
		.PRIMARY_IID_READ_I(evt[6]), .RX_WORD_VALID_I(vld), .RX_WORD_I(word),
		.RX_MARK_BIT_I(mark), .SERIAL_OUT_I(ser), .FRAC_GEN_ON_O(gen_on), .FRAC_M_O(fm),
		.FRAC_N_O(fn), .NET_MODE_O(mode), .PARITY_CHECK_OFF_O(par_off),
		.TX_MARK_BIT_O(tx_mark), .TX_NINE_BIT_O(tx9), .RX_NINE_BIT_O(rx9),
		.NINE_BIT_DATA_O(d9), .NET_IRQ_O(irq), .SERIAL_OUT_PIN_O(pin), .SERIAL_OUT_OE_O(oe));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// one-cycle bus strobes
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic ck_reg(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	// reset values, read-only places and an unmapped address
	task automatic t_reset;
		logic [31:0] ra [7] = '{ast, asc, aen, aid, amt, afd, 32'hffff0730};
		logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h4, 32'h1, 32'haa, 32'h0, 32'h0};
		chk("m factor", {29'h0, fm}, 32'h4);
		wr_reg(ast, 32'hff);
		wr_reg(aid, 32'hff);
		wr_reg(32'hffff0730, 32'hff);
		for (int k = 0; k < 7; k++) begin
			ck_reg(ra[k], rv[k]);
		end
		wr_reg(asc, 32'hffffff5a);
		wr_reg(amt, 32'h3c);
		ck_reg(asc, 32'h5a);
		ck_reg(amt, 32'h3c);
	endtask
	// modem pin changes, then a change landing on the clearing read
	task automatic t_modem;
		int pi [5] = '{`UMSNA_IN_CTS, `UMSNA_IN_DSR, `UMSNA_IN_RING_N, `UMSNA_IN_RING_N, `UMSNA_IN_DCD};
		logic pv [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
		logic [7:0] ev [5] = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hb8};
		logic [31:0] r1, r2, r3;
		for (int k = 0; k < 5; k++) begin
			u_mdm.set_pin(pi[k], pv[k]);
			settle(8);
			ck_reg(ast, {24'h0, ev[k]});
		end
		ck_reg(ast, 32'hb0);
		for (int k = 0; k < 6; k++) begin
			u_mdm.set_pin(`UMSNA_IN_CTS, ~cts);
			settle(k);
			rd_reg(ast, r1);
			rd_reg(ast, r2);
			rd_reg(ast, r3);
			chk("delta kept", {31'h0, r1[0] | r2[0] | r3[0]}, 32'h1);
			settle(8);
			rd_reg(ast, r1);
		end
	endtask
	// divider fields, every m code
	task automatic t_frac;
		logic [15:0] d;
		for (int m = 0; m < 4; m++) begin
			d = 16'he2a5;
			d[12:11] = m[1:0];
			wr_reg(afd, {16'h0, d});
			ck_reg(afd, {16'h0, d & 16'h9fff});
			chk("m factor", {29'h0, fm}, (m == 0) ? 32'h4 : m);
			chk("n factor", {21'h0, fn}, 32'h2a5);
			chk("frac gen", {31'h0, gen_on}, 32'h1);
		end
		wr_reg(afd, 32'h0);
		settle(2);
		chk("frac gen", {31'h0, gen_on}, 32'h0);
	endtask
	// network enable bits against mode, nine-bit, pin and marker outputs
	task automatic t_net;
		logic [7:0] en [6] = '{8'h68, 8'hec, 8'he8, 8'h84, 8'h81, 8'h01};
		logic [7:0] sc [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
		logic [6:0] ex [6] = '{7'h04, 7'h7e, 7'h7b, 7'h46, 7'h43, 7'h04};
		logic [6:0] got;
		for (int k = 0; k < 6; k++) begin
			wr_reg(aen, {24'h0, en[k]});
			wr_reg(asc, {24'h0, sc[k]});
			settle(2);
			got = {mode, tx9, rx9, d9, oe, par_off, tx_mark};
			chk("net config", {25'h0, got}, {25'h0, ex[k]});
		end
		ck_reg(asc, 32'h1);
	endtask
	// one event step: enable value, strobes, received word, expected identify and irq
	task automatic step(input logic [7:0] en, input logic [6:0] ev, input logic [9:0] w,
			input logic [7:0] exp, input logic eirq);
		wr_reg(aen, {24'h0, en});
		@(posedge mclk);
		evt <= ev;
		vld <= w[9];
		mark <= w[8];
		word <= w[7:0];
		@(posedge mclk);
		evt <= 7'h0;
		vld <= 1'b0;
		settle(3);
		chk("net irq", {31'h0, irq}, {31'h0, eirq});
		ck_reg(aid, {24'h0, exp});
	endtask
	task automatic t_iid;
		logic [31:0] r;
		wr_reg(asc, 32'h0);
		rd_reg(ast, r);
		step(8'hb4, 7'h00, 10'h33c, 8'h0c, 1'b1);
		step(8'hb4, 7'h01, 10'h000, 8'h06, 1'b1);
		step(8'hb4, 7'h02, 10'h000, 8'h0c, 1'b1);
		step(8'hb4, 7'h08, 10'h000, 8'h01, 1'b0);
		step(8'hb4, 7'h00, 10'h33d, 8'h01, 1'b0);
		step(8'hb4, 7'h00, 10'h23c, 8'h01, 1'b0);
		step(8'h94, 7'h00, 10'h33c, 8'h01, 1'b0);
		step(8'hb6, 7'h00, 10'h23c, 8'h0c, 1'b1);
		step(8'ha6, 7'h08, 10'h000, 8'h01, 1'b0);
		step(8'ha4, 7'h04, 10'h000, 8'h04, 1'b0);
		step(8'ha4, 7'h10, 10'h000, 8'h04, 1'b0);
		step(8'ha4, 7'h08, 10'h000, 8'h02, 1'b0);
		step(8'ha4, 7'h40, 10'h000, 8'h01, 1'b0);
		step(8'ha5, 7'h10, 10'h000, 8'h0a, 1'b0);
		step(8'ha5, 7'h20, 10'h000, 8'h01, 1'b0);
		u_mdm.set_pin(`UMSNA_IN_DSR, 1'b0);
		settle(8);
		ck_reg(aid, 32'h0);
		rd_reg(ast, r);
		ck_reg(aid, 32'h1);
	endtask
	// reset in mid-run restores register values
	task automatic t_rerst;
		wr_reg(asc, 32'h77);
		@(posedge mclk);
		rst_n <= 1'b0;
		settle(3);
		chk("reset m factor", {29'h0, fm}, 32'h4);
		chk("reset pin and enable", {30'h0, pin, oe}, 32'h2);
		chk("reset read data", rdata, 32'h0);
		@(posedge mclk);
		rst_n <= 1'b1;
		settle(8);
		ck_reg(ast, 32'h90);
		ck_reg(asc, 32'h0);
		ck_reg(aen, 32'h4);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		settle(8);
		t_reset();
		t_modem();
		t_frac();
		t_net();
		t_iid();
		t_rerst();
		end_sim();
	end
	// hang guard
	initial begin
		#2000000;
		failures++;
		end_sim();
	end
endmodule // test_umsna_top
`default_nettype wire
